/* mfw_irq_wakeup.v */
// multi-function interrupt group: low-voltage and data-memory
// write sources, vector request, return handling and wake-up
// assumes the core drives take/return pulses on clk_i, the
// detector pin is asynchronous and the bus is a plain strobe port
`timescale 1ns/100ps
`include "mfw_consts.vh"

module mfw_irq_wakeup (
    input  wire              clk_i,
    input  wire              rst_i,
    // register port
    input  wire [`MFW_AW-1:0] addr_i,
    input  wire [`MFW_DW-1:0] wdata_i,
    input  wire              wr_i,
    input  wire              rd_i,
    output wire [`MFW_DW-1:0] rdata_o,
    // event sources
    input  wire              lv_low_i,
    input  wire              nvm_done_i,
    input  wire [7:0]        other_rise_i,
    // core sequencer and stack
    input  wire              stack_full_i,
    input  wire              vec_take_i,
    input  wire              return_from_irq_instr_i,
    input  wire              subroutine_return_instr_i,
    input  wire              halted_i,
    output wire              vec_req_o,
    output wire [`MFW_VW-1:0] vec_addr_o,
    output wire              push_pc_o,
    output wire              pop_pc_o,
    output wire              wakeup_o,
    output wire              irq_o
);
    // synchroniser for the detector pin
    reg  lv_meta_q;
    reg  lv_sync_q;

    // enables and housekeeping registers
    reg                  global_irq_en_q;
    reg                  global_irq_en_d;
    reg                  mf_en_q;
    reg                  low_voltage_irq_en_q;
    reg                  nvm_write_irq_en_q;
    reg  [`MFW_NEV-1:0]   ev_st_q;
    reg  [`MFW_NEV-1:0]   ev_en_q;
    reg  [`MFW_DW-1:0]    rdata_q;
    reg  [`MFW_DW-1:0]    rdata_d;
    reg  [`MFW_VW-1:0]    vec_addr_q;

    wire wr_ctrl;
    wire wr_src;
    wire wr_clr;
    wire wr_en;
    wire low_voltage_req_flag;
    wire nvm_write_done_flag;
    wire multi_source_req_flag;
    wire lv_rise;
    wire nv_rise;
    wire mf_rise;
    wire lv_member;
    wire nv_member;
    reg  lv_member_q;
    reg  nv_member_q;
    wire mf_set;
    wire take;
    wire any_rise;
    wire async_wake;
    wire [`MFW_NEV-1:0] ev_set;

    // write decode
    assign wr_ctrl = wr_i & (addr_i == `MFW_OFF_CTRL);
    assign wr_src  = wr_i & (addr_i == `MFW_OFF_SRC);
    assign wr_clr  = wr_i & (addr_i == `MFW_OFF_CLR);
    assign wr_en   = wr_i & (addr_i == `MFW_OFF_EN);

    // two flip-flops ahead of the flag's use of the detector pin; the wake path uses it raw
    always @(posedge clk_i) begin
        if (rst_i) begin
            lv_meta_q <= `MFW_RST_BIT;
            lv_sync_q <= `MFW_RST_BIT;
        end else begin
            lv_meta_q <= lv_low_i;
            lv_sync_q <= lv_meta_q;
        end
    end

    // low-voltage flag, set every cycle the supply reads low
    mfw_flag u_lv_flag (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (lv_sync_q),
        .clr_i  (1'b0),
        .wr_i   (wr_src),
        .wd_i   (wdata_i[`MFW_B_LVF]),
        .flag_o (low_voltage_req_flag),
        .rise_o (lv_rise)
    );

    // memory flag, set at the end of each erase or write cycle
    mfw_flag u_nv_flag (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (nvm_done_i),
        .clr_i  (1'b0),
        .wr_i   (wr_src),
        .wd_i   (wdata_i[`MFW_B_NVF]),
        .flag_o (nvm_write_done_flag),
        .rise_o (nv_rise)
    );

    // an enabled member raising its request feeds the shared flag
    assign lv_member = low_voltage_req_flag & low_voltage_irq_en_q;
    assign nv_member = nvm_write_done_flag & nvm_write_irq_en_q;

    always @(posedge clk_i) begin
        if (rst_i) begin
            lv_member_q <= `MFW_RST_BIT;
            nv_member_q <= `MFW_RST_BIT;
        end else begin
            lv_member_q <= lv_member;
            nv_member_q <= nv_member;
        end
    end

    // edge, not level, so a serviced member does not re-fire
    assign mf_set = (lv_member & ~lv_member_q)
                  | (nv_member & ~nv_member_q);

    // shared flag, cleared by hardware when the vector is taken
    mfw_flag u_mf_flag (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (mf_set),
        .clr_i  (take),
        .wr_i   (wr_ctrl),
        .wd_i   (wdata_i[`MFW_B_MFF]),
        .flag_o (multi_source_req_flag),
        .rise_o (mf_rise)
    );

    // request the shared vector only with room left on the stack
    assign vec_req_o = global_irq_en_q & mf_en_q
                     & multi_source_req_flag
                     & ~stack_full_i;
    assign take      = vec_req_o & vec_take_i;

    // entry pushes the program counter and nothing else
    assign push_pc_o = take;

    // either return instruction pops the program counter
    assign pop_pc_o  = return_from_irq_instr_i
                     | subroutine_return_instr_i;

    // global enable: cleared on entry, set again by the irq return
    always @* begin
        global_irq_en_d = global_irq_en_q;
        if (take) begin
            global_irq_en_d = 1'b0;
        end else if (return_from_irq_instr_i) begin
            global_irq_en_d = 1'b1;
        end else if (wr_ctrl) begin
            global_irq_en_d = wdata_i[`MFW_B_GIE];
        end
    end

    // plain return leaves the enable untouched
    always @(posedge clk_i) begin
        if (rst_i) begin
            global_irq_en_q <= `MFW_RST_BIT;
        end else begin
            global_irq_en_q <= global_irq_en_d;
        end
    end

    // software-written enables and the fixed vector address
    always @(posedge clk_i) begin
        if (rst_i) begin
            mf_en_q              <= `MFW_RST_BIT;
            low_voltage_irq_en_q <= `MFW_RST_BIT;
            nvm_write_irq_en_q   <= `MFW_RST_BIT;
            ev_en_q              <= `MFW_RST_EV;
            vec_addr_q           <= `MFW_VEC_ADDR;
        end else begin
            vec_addr_q <= `MFW_VEC_ADDR;
            if (wr_ctrl) begin
                mf_en_q <= wdata_i[`MFW_B_MFE];
            end
            if (wr_src) begin
                low_voltage_irq_en_q <= wdata_i[`MFW_B_LVE];
                nvm_write_irq_en_q   <= wdata_i[`MFW_B_NVE];
            end
            if (wr_en) begin
                ev_en_q <= wdata_i[`MFW_NEV-1:0];
            end
        end
    end

    // wake on any request flag going high, enables ignored
    assign any_rise = lv_rise | nv_rise | mf_rise
                    | (|other_rise_i);

    // raw detector path needs no clock edge to wake the core
    assign async_wake = lv_low_i & ~low_voltage_req_flag;

    assign wakeup_o = halted_i & (any_rise | async_wake);

    // sticky event status, set beats the clear write
    assign ev_set[`MFW_EV_WAKE] = wakeup_o;
    assign ev_set[`MFW_EV_TAKE] = take;
    assign ev_set[`MFW_EV_LV]   = lv_rise;
    assign ev_set[`MFW_EV_NV]   = nv_rise;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ev_st_q <= `MFW_RST_EV;
        end else begin
            ev_st_q <= ev_set
                     | (ev_st_q & ~({`MFW_NEV{wr_clr}}
                                  & wdata_i[`MFW_NEV-1:0]));
        end
    end

    assign irq_o = |(ev_st_q & ev_en_q);

    // read mux, unmapped and write-only offsets read as zero
    always @* begin
        rdata_d = `MFW_RST_BYTE;
        case (addr_i)
            `MFW_OFF_CTRL: begin
                rdata_d[`MFW_B_GIE] = global_irq_en_q;
                rdata_d[`MFW_B_MFE] = mf_en_q;
                rdata_d[`MFW_B_MFF] = multi_source_req_flag;
            end
            `MFW_OFF_SRC: begin
                rdata_d[`MFW_B_LVE] = low_voltage_irq_en_q;
                rdata_d[`MFW_B_NVE] = nvm_write_irq_en_q;
                rdata_d[`MFW_B_LVF] = low_voltage_req_flag;
                rdata_d[`MFW_B_NVF] = nvm_write_done_flag;
            end
            `MFW_OFF_STAT: begin
                rdata_d[`MFW_NEV-1:0] = ev_st_q;
            end
            `MFW_OFF_EN: begin
                rdata_d[`MFW_NEV-1:0] = ev_en_q;
            end
            `MFW_OFF_INFO: begin
                rdata_d[`MFW_B_HALT] = halted_i;
                rdata_d[`MFW_B_FULL] = stack_full_i;
                rdata_d[`MFW_B_LVIN] = lv_sync_q;
            end
            default: begin
                rdata_d = `MFW_RST_BYTE;
            end
        endcase
    end

    // read data stand for one cycle after the strobe, zero otherwise
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= `MFW_RST_BYTE;
        end else if (rd_i) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= `MFW_RST_BYTE;
        end
    end

    assign rdata_o    = rdata_q;
    assign vec_addr_o = vec_addr_q;
endmodule // mfw_irq_wakeup

/* mfw_consts.vh */
// constants for the multi-function interrupt and wake-up block
// assumes a single 10 MHz clock and an 8-bit register port
//
// Operation
// - low supply sets flag, routed via shared vector
// - low-voltage vectors when all enables set, stack free
// - low-voltage entry clears global enable, shared flag
// - erase or write end sets memory flag
// - memory flag vectors when enables set, stack free
// - memory entry clears global enable, shared flag only
// - any rising request flag wakes sleep or idle
// - wake detection works with oscillator stopped
// - wake ignores every enable bit
// - set flag stays set until serviced or cleared
// - entry pushes program counter only
// - return-from-interrupt pops and sets global enable
// - plain return pops, leaves global enable unchanged
`ifndef MFW_CONSTS_VH
`define MFW_CONSTS_VH

`define MFW_AW          3
`define MFW_DW          8
`define MFW_VW          12

// register offsets
`define MFW_OFF_CTRL    3'h0
`define MFW_OFF_SRC     3'h1
`define MFW_OFF_STAT    3'h2
`define MFW_OFF_CLR     3'h3
`define MFW_OFF_EN      3'h4
`define MFW_OFF_INFO    3'h5

// control register fields
`define MFW_B_GIE       0
`define MFW_B_MFE       1
`define MFW_B_MFF       2

// source register fields
`define MFW_B_LVE       0
`define MFW_B_NVE       1
`define MFW_B_LVF       2
`define MFW_B_NVF       3

// event status fields
`define MFW_EV_WAKE     0
`define MFW_EV_TAKE     1
`define MFW_EV_LV       2
`define MFW_EV_NV       3
`define MFW_NEV         4

// information register fields
`define MFW_B_HALT      0
`define MFW_B_FULL      1
`define MFW_B_LVIN      2

// reset values
`define MFW_RST_BIT     1'b0
`define MFW_RST_EV      4'h0
`define MFW_RST_BYTE    8'h00
`define MFW_VEC_ADDR    12'h010

`endif

/* mfw_flag.v */
// one sticky request flag with hardware set, hardware clear and
// software write; assumes all inputs are on clk_i
`timescale 1ns/100ps
`include "mfw_consts.vh"

module mfw_flag (
    input  wire clk_i,
    input  wire rst_i,
    input  wire set_i,
    input  wire clr_i,
    input  wire wr_i,
    input  wire wd_i,
    output wire flag_o,
    output wire rise_o
);
    reg flag_q;
    reg flag_d;

    // set beats both clears so an event is never lost
    always @* begin
        flag_d = flag_q;
        if (set_i) begin
            flag_d = 1'b1;
        end else if (clr_i) begin
            flag_d = 1'b0;
        end else if (wr_i) begin
            flag_d = wd_i;
        end
    end

    // holds until cleared, enables play no part
    always @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= `MFW_RST_BIT;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;
    // flag about to go from low to high
    assign rise_o = flag_d & ~flag_q;
endmodule // mfw_flag

/* mfw_irq_wakeup_properties.sv */
// checker for the multi-function interrupt and wake-up block
// assumes it is bound to mfw_irq_wakeup and sees only its ports
`timescale 1ns/100ps
`include "mfw_consts.vh"
module mfw_irq_wakeup_chk (
    input wire               clk_i,
    input wire               rst_i,
    input wire [7:0]         other_rise_i,
    input wire               stack_full_i,
    input wire               vec_take_i,
    input wire               return_from_irq_instr_i,
    input wire               subroutine_return_instr_i,
    input wire               halted_i,
    input wire               vec_req_o,
    input wire [`MFW_VW-1:0] vec_addr_o,
    input wire               push_pc_o,
    input wire               pop_pc_o,
    input wire               wakeup_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // vector entry and stack handling
    push_pair_a: assert property (push_pc_o == (vec_req_o && vec_take_i))
        else $error("push does not match a taken vector");
    take_drop_a: assert property (push_pc_o |=> !vec_req_o)
        else $error("vector still requested after entry");
    full_block_a: assert property (stack_full_i |-> !vec_req_o)
        else $error("vector requested with full stack");
    vec_const_a: assert property (vec_addr_o == `MFW_VEC_ADDR)
        else $error("vector address wrong");
    // return handling
    return_from_irq_instr_pop_a: assert property (return_from_irq_instr_i |-> pop_pc_o)
        else $error("no pop on return from interrupt");
    ret_pop_a: assert property (pop_pc_o |-> (return_from_irq_instr_i
        || subroutine_return_instr_i))
        else $error("pop without a return");
    // wake-up
    wake_rise_a: assert property (halted_i && (|other_rise_i) |-> wakeup_o)
        else $error("rising flag did not wake");
    wake_halt_a: assert property (wakeup_o |-> halted_i)
        else $error("wake while running");
    cover property (push_pc_o);
    cover property (halted_i && wakeup_o);
    cover property (pop_pc_o ##1 vec_req_o);
endmodule // mfw_irq_wakeup_chk

bind mfw_irq_wakeup mfw_irq_wakeup_chk mfw_irq_wakeup_chk_inst (
    .clk_i(clk_i), .rst_i(rst_i), .other_rise_i(other_rise_i),
    .stack_full_i(stack_full_i), .vec_take_i(vec_take_i), .halted_i(halted_i),
    .return_from_irq_instr_i(return_from_irq_instr_i), .vec_req_o(vec_req_o),
    .subroutine_return_instr_i(subroutine_return_instr_i), .vec_addr_o(vec_addr_o),
    .push_pc_o(push_pc_o), .pop_pc_o(pop_pc_o), .wakeup_o(wakeup_o));

/* mfw_core_model.sv */
// core sequencer stand-in: takes a requested vector at once or after
// a short stall; assumes vec_req_i is a level on clk_i
`timescale 1ns/100ps
module mfw_core_model (
    input  wire clk_i,
    input  wire rst_i,
    input  wire vec_req_i,
    input  wire slow_i,
    output reg  vec_take_o
);
    reg [1:0] wait_q;
    // one take per request, no nested call from the service code
    always @(posedge clk_i) begin
        vec_take_o <= 1'b0;
        if (rst_i || !vec_req_i || vec_take_o) begin
            wait_q <= 2'h0;
        end else if (slow_i && wait_q != 2'h3) begin
            wait_q <= wait_q + 2'h1;
        end else begin
            vec_take_o <= 1'b1;
        end
    end
endmodule // mfw_core_model

/* mfw_irq_wakeup_tb_top.sv */
// self-checking bench for the multi-function interrupt and wake-up block
// assumes the core model answers vector requests; 100 ns clock
`timescale 1ns/100ps
module mfw_irq_wakeup_tb_top;
    reg         clk_i = 1'b0;
    reg         rst_i = 1'b1;
    reg  [2:0]  addr_i = 3'h0;
    reg  [7:0]  wdata_i = 8'h00;
    reg         wr_i = 1'b0;
    reg         rd_i = 1'b0;
    reg         lv_low_i = 1'b0;
    reg         nvm_done_i = 1'b0;
    reg  [7:0]  other_rise_i = 8'h00;
    reg         stack_full_i = 1'b0;
    reg         return_from_irq_instr_q = 1'b0;
    reg         ret_q = 1'b0;
    reg         halted_i = 1'b0;
    reg         slow_i = 1'b0;
    wire [7:0]  rdata_o;
    wire [11:0] vec_addr_o;
    wire        vec_req_o, vec_take_i, push_pc_o, pop_pc_o, wakeup_o, irq_o;
    integer     failures = 0;
    integer     checks_done = 0;
    integer     pushes = 0;
    integer     i;
    reg  [18:0] rows [0:5];
    always #50 clk_i = ~clk_i;
    mfw_irq_wakeup mfw_irq_wakeup_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lv_low_i(lv_low_i),
        .nvm_done_i(nvm_done_i), .other_rise_i(other_rise_i), .stack_full_i(stack_full_i),
        .vec_take_i(vec_take_i), .return_from_irq_instr_i(return_from_irq_instr_q), .halted_i(halted_i),
        .subroutine_return_instr_i(ret_q), .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o),
        .push_pc_o(push_pc_o), .pop_pc_o(pop_pc_o), .wakeup_o(wakeup_o), .irq_o(irq_o));
    mfw_core_model mfw_core_model_inst (.clk_i(clk_i), .rst_i(rst_i), .vec_req_i(vec_req_o),
        .slow_i(slow_i), .vec_take_o(vec_take_i));
    // count vector entries
    always @(posedge clk_i) if (push_pc_o === 1'b1) pushes <= pushes + 1;
    task chk(input [7:0] got, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge clk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rd(input [2:0] a, input [7:0] e);
        begin
            @(posedge clk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge clk_i);
            rd_i <= 1'b0;
            #1 chk(rdata_o, e);
        end
    endtask
    task wait_push(input [7:0] n);
        integer k;
        begin
            for (k = 0; k < 30 && pushes < n; k = k + 1) @(posedge clk_i);
            chk(pushes[7:0], n);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d failures %0d", checks_done, failures);
            if (failures == 0 && checks_done > 0) begin
                $display("Simulation passed");
            end else begin
                $display("Simulation failed");
            end
            $finish;
        end
    endtask
    // watchdog
    initial begin
        #(3000 * 100);
        failures = failures + 1;
        final_report;
    end
    // main sequence
    initial begin
        rows[0] = {3'h4, 8'hFF, 8'h0F};
        rows[1] = {3'h0, 8'hFA, 8'h02};
        rows[2] = {3'h1, 8'hF3, 8'h03};
        rows[3] = {3'h6, 8'hFF, 8'h00};
        rows[4] = {3'h2, 8'hFF, 8'h00};
        rows[5] = {3'h5, 8'hFF, 8'h00};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 8; i = i + 1) rd(i[2:0], 8'h00);
        for (i = 0; i < 6; i = i + 1) begin
            wr(rows[i][18:16], rows[i][15:8]);
            rd(rows[i][18:16], rows[i][7:0]);
        end
        // memory write end, vector taken at once
        wr(3'h0, 8'h03);
        @(posedge clk_i);
        nvm_done_i <= 1'b1;
        @(posedge clk_i);
        nvm_done_i <= 1'b0;
        wait_push(8'h01);
        rd(3'h0, 8'h02);
        rd(3'h1, 8'h0B);
        rd(3'h2, 8'h0A);
        chk({7'h00, irq_o}, 8'h01);
        wr(3'h3, 8'h0F);
        #1 chk({7'h00, irq_o}, 8'h00);
        // return from interrupt, then plain return
        @(posedge clk_i);
        return_from_irq_instr_q <= 1'b1;
        @(posedge clk_i);
        return_from_irq_instr_q <= 1'b0;
        rd(3'h0, 8'h03);
        wr(3'h0, 8'h02);
        ret_q <= 1'b1;
        @(posedge clk_i);
        ret_q <= 1'b0;
        rd(3'h0, 8'h02);
        wr(3'h1, 8'h03);
        // low supply held off by a full stack, slow core
        wr(3'h0, 8'h03);
        slow_i <= 1'b1;
        stack_full_i <= 1'b1;
        lv_low_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rd(3'h1, 8'h07);
        chk(pushes[7:0], 8'h01);
        stack_full_i <= 1'b0;
        lv_low_i <= 1'b0;
        wait_push(8'h02);
        rd(3'h0, 8'h02);
        rd(3'h1, 8'h07);
        wr(3'h1, 8'h03);
        // wake from sleep with interrupts off
        halted_i <= 1'b1;
        @(posedge clk_i);
        other_rise_i <= 8'h80;
        #1 chk({7'h00, wakeup_o}, 8'h01);
        @(posedge clk_i);
        other_rise_i <= 8'h00;
        wr(3'h1, 8'h0B);
        // preset the shared flag too, so no member edge can raise it
        wr(3'h0, 8'h06);
        nvm_done_i <= 1'b1;
        #1 chk({7'h00, wakeup_o}, 8'h00);
        @(posedge clk_i);
        nvm_done_i <= 1'b0;
        lv_low_i <= 1'b1;
        #1 chk({7'h00, wakeup_o}, 8'h01);
        lv_low_i <= 1'b0;
        halted_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        // hardware set against software clear in one cycle
        addr_i <= 3'h1;
        wdata_i <= 8'h03;
        wr_i <= 1'b1;
        nvm_done_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        nvm_done_i <= 1'b0;
        rd(3'h1, 8'h0B);
        chk(pushes[7:0], 8'h02);
        // reset in mid-run clears flags and enables
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(3'h1, 8'h00);
        rd(3'h0, 8'h00);
        final_report;
    end
endmodule // mfw_irq_wakeup_tb_top
